// ### hw/reset_cause_flags.v
// Reset-cause flags, sleep regulator control and watchdog enable over AXI4-Lite
//
// The placing of the registers and the AXI4-Lite register port are this design's own decisions.
`timescale 1ns/1ps
`default_nettype none
`include "reset_cause_defines.vh"
module reset_cause_flags (
  input wire clock,
  input wire reset,
  // Reset-cause event levels from the reset controller (asynchronous)
  input wire pinResetEvent,
  input wire softResetEvent,
  input wire watchdogTimeoutEvent,
  input wire configMismatchEvent,
  // Power-mode status levels from the core (same clock)
  input wire sleepEntered,
  input wire idleEntered,
  // Watchdog configuration field (static strap)
  input wire [1:0] watchdogConfigEnable,
  // AXI4-Lite slave
  input wire [3:0] s_axi_awaddr,
  input wire s_axi_awvalid,
  output reg s_axi_awready,
  input wire [31:0] s_axi_wdata,
  input wire [3:0] s_axi_wstrb,
  input wire s_axi_wvalid,
  output reg s_axi_wready,
  output reg [1:0] s_axi_bresp,
  output reg s_axi_bvalid,
  input wire s_axi_bready,
  input wire [3:0] s_axi_araddr,
  input wire s_axi_arvalid,
  output reg s_axi_arready,
  output reg [31:0] s_axi_rdata,
  output reg [1:0] s_axi_rresp,
  output reg s_axi_rvalid,
  input wire s_axi_rready,
  // Block outputs
  output reg watchdogEnable,
  output reg coreRegulatorSleepActive,
  output reg flashRegulatorSleepActive,
  output reg interrupt
);

  // Merge new 16-bit data under byte strobes
  function [15:0] mergeBytes;
    input [15:0] oldVal;
    input [31:0] data;
    input [3:0] strb;
    begin
      mergeBytes = oldVal;
      if (strb[0])
        mergeBytes[7:0] = data[7:0];
      if (strb[1])
        mergeBytes[15:8] = data[15:8];
    end
  endfunction

  // Word index of a byte address; registers are one aligned word apart
  // The low two address bits are ignored, so unaligned accesses alias
  function [1:0] regIndex;
    input [3:0] addr;
    begin
      regIndex = addr[3:2];
    end
  endfunction

  wire [3:0] eventSync;
  reg [3:0] eventPrev_reg;
  wire [3:0] eventRise;

  reg [15:0] resetCause_reg;
  reg [15:0] resetCause_next;
  reg [`IRQ_WIDTH-1:0] irqStatus_reg;
  reg [`IRQ_WIDTH-1:0] irqStatus_next;
  reg [`IRQ_WIDTH-1:0] irqMask_reg;
  reg [`IRQ_WIDTH-1:0] irqMask_next;

  reg [3:0] awAddr_reg;
  reg awHeld_reg;
  reg [31:0] wData_reg;
  reg [3:0] wStrb_reg;
  reg wHeld_reg;
  wire doWrite;
  wire writeCause;
  wire writeStatus;
  wire writeMask;
  wire [15:0] causeWritten;
  reg [31:0] readData;
  reg readOk;

  // Event levels come from the reset controller's own timing
  sync_two_flop #(
    .WIDTH(4)
  ) eventSyncer (
    .clock(clock),
    .reset(reset),
    .asyncIn({configMismatchEvent, watchdogTimeoutEvent, softResetEvent, pinResetEvent}),
    .syncOut(eventSync)
  );

  // Edge detect on the synchronised levels, one pulse per event
  always @(posedge clock or posedge reset)
  begin
    if (reset)
      eventPrev_reg <= 4'h0;
    else
      eventPrev_reg <= eventSync;
  end
  assign eventRise = eventSync & ~eventPrev_reg;

  // Write address and data captured independently, in either order
  assign doWrite = awHeld_reg && wHeld_reg && !s_axi_bvalid;
  // Decode on word indices of equal width on both sides
  assign writeCause = doWrite && (regIndex(awAddr_reg) == regIndex(`ADDR_RESET_CAUSE_CONTROL));
  assign writeStatus = doWrite && (regIndex(awAddr_reg) == regIndex(`ADDR_IRQ_STATUS));
  assign writeMask = doWrite && (regIndex(awAddr_reg) == regIndex(`ADDR_IRQ_MASK));
  assign causeWritten = mergeBytes(resetCause_reg, wData_reg, wStrb_reg) & `RCC_IMPL_MASK;

  always @(posedge clock or posedge reset)
  begin
    if (reset)
    begin
      s_axi_awready <= 1'b1;
      s_axi_wready <= 1'b1;
      awHeld_reg <= 1'b0;
      wHeld_reg <= 1'b0;
      awAddr_reg <= 4'h0;
      wData_reg <= 32'h00000000;
      wStrb_reg <= 4'h0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= `RESP_OKAY;
    end
    else
    begin
      if (s_axi_awvalid && s_axi_awready)
      begin
        awAddr_reg <= s_axi_awaddr;
        awHeld_reg <= 1'b1;
        s_axi_awready <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready)
      begin
        wData_reg <= s_axi_wdata;
        wStrb_reg <= s_axi_wstrb;
        wHeld_reg <= 1'b1;
        s_axi_wready <= 1'b0;
      end
      if (doWrite)
      begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= (writeCause || writeStatus || writeMask) ? `RESP_OKAY : `RESP_SLVERR;
        awHeld_reg <= 1'b0;
        wHeld_reg <= 1'b0;
      end
      if (s_axi_bvalid && s_axi_bready)
      begin
        s_axi_bvalid <= 1'b0;
        s_axi_awready <= 1'b1;
        s_axi_wready <= 1'b1;
      end
    end
  end

  // Next value of the control register: software write, then hardware sets
  always @*
  begin
    resetCause_next = resetCause_reg;
    if (writeCause)
      resetCause_next = causeWritten;
    // Hardware events win over a simultaneous software clear
    if (eventRise[0])
      resetCause_next[`BIT_PIN_RESET] = 1'b1;
    if (eventRise[1])
      resetCause_next[`BIT_SOFT_RESET] = 1'b1;
    if (eventRise[2])
      resetCause_next[`BIT_WDT_TIMEOUT] = 1'b1;
    if (eventRise[3])
      resetCause_next[`BIT_CONFIG_MISMATCH] = 1'b1;
    if (sleepEntered)
      resetCause_next[`BIT_SLEEP] = 1'b1;
    if (idleEntered)
      resetCause_next[`BIT_IDLE] = 1'b1;
  end

  // Interrupt status: write one to clear, set wins over clear
  always @*
  begin
    irqStatus_next = irqStatus_reg;
    if (writeStatus && wStrb_reg[0])
      irqStatus_next = irqStatus_reg & ~wData_reg[`IRQ_WIDTH-1:0];
    irqStatus_next = irqStatus_next | eventRise;
  end

  // Interrupt mask: plain read/write, low byte strobe needed
  // A write without the low strobe leaves the mask untouched
  always @*
  begin
    irqMask_next = irqMask_reg;
    if (writeMask && wStrb_reg[0])
      irqMask_next = wData_reg[`IRQ_WIDTH-1:0];
  end

  // Register state; power-on value marks brown-out and power-on
  always @(posedge clock or posedge reset)
  begin
    if (reset)
    begin
      resetCause_reg <= `RCC_RESET_VALUE;
      irqStatus_reg <= {`IRQ_WIDTH{1'b0}};
      irqMask_reg <= {`IRQ_WIDTH{1'b0}};
    end
    else
    begin
      resetCause_reg <= resetCause_next;
      irqStatus_reg <= irqStatus_next;
      irqMask_reg <= irqMask_next;
    end
  end

  // Read decode; unmapped addresses answer SLVERR with zero data
  always @*
  begin
    readData = 32'h00000000;
    readOk = 1'b1;
    case (regIndex(s_axi_araddr))
      regIndex(`ADDR_RESET_CAUSE_CONTROL): readData = {16'h0000, resetCause_reg};
      regIndex(`ADDR_IRQ_STATUS): readData = {28'h0000000, irqStatus_reg};
      regIndex(`ADDR_IRQ_MASK): readData = {28'h0000000, irqMask_reg};
      // Fourth word is unmapped
      default: readOk = 1'b0;
    endcase
  end

  // Read channel: one read at a time, answer one cycle after address
  always @(posedge clock or posedge reset)
  begin
    if (reset)
    begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h00000000;
      s_axi_rresp <= `RESP_OKAY;
    end
    else
    begin
      if (s_axi_arvalid && s_axi_arready)
      begin
        s_axi_arready <= 1'b0;
        s_axi_rvalid <= 1'b1;
        s_axi_rdata <= readData;
        s_axi_rresp <= readOk ? `RESP_OKAY : `RESP_SLVERR;
      end
      else if (s_axi_rvalid && s_axi_rready)
      begin
        s_axi_rvalid <= 1'b0;
        s_axi_arready <= 1'b1;
      end
    end
  end

  // Watchdog and regulator controls registered; config strap is static
  // Outputs lag the control register by one clock, harmless for levels
  always @(posedge clock or posedge reset)
  begin
    if (reset)
    begin
      watchdogEnable <= 1'b0;
      coreRegulatorSleepActive <= 1'b0;
      flashRegulatorSleepActive <= 1'b0;
    end
    else
    begin
      // Unprogrammed field overrides the software bit
      watchdogEnable <= (watchdogConfigEnable == `WDT_CFG_ALWAYS_ON) ||
        resetCause_reg[`BIT_WDT_SOFT_EN];
      coreRegulatorSleepActive <= resetCause_reg[`BIT_CORE_REG_SLEEP];
      flashRegulatorSleepActive <= resetCause_reg[`BIT_FLASH_REG_SLEEP];
    end
  end

  // Level interrupt from unmasked sticky status bits
  // Registered so the pin never glitches during a status write
  always @(posedge clock or posedge reset)
  begin
    if (reset)
      interrupt <= 1'b0;
    else
      interrupt <= |(irqStatus_reg & irqMask_reg);
  end
endmodule // reset_cause_flags
`default_nettype wire

// ### common/reset_cause_defines.vh
// Constants for the reset-cause and sleep-regulator control block
`ifndef RESET_CAUSE_DEFINES_VH
`define RESET_CAUSE_DEFINES_VH

// Register byte addresses
`define ADDR_RESET_CAUSE_CONTROL 4'h0
`define ADDR_IRQ_STATUS 4'h4
`define ADDR_IRQ_MASK 4'h8

// Field positions in reset_cause_control
`define BIT_POWERON 0
`define BIT_BROWNOUT 1
`define BIT_IDLE 2
`define BIT_SLEEP 3
`define BIT_WDT_TIMEOUT 4
`define BIT_WDT_SOFT_EN 5
`define BIT_SOFT_RESET 6
`define BIT_PIN_RESET 7
`define BIT_CORE_REG_SLEEP 8
`define BIT_CONFIG_MISMATCH 9
`define BIT_FLASH_REG_SLEEP 11

// Implemented bits and power-on value
`define RCC_IMPL_MASK 16'h0BFF
`define RCC_RESET_VALUE 16'h0003

// Interrupt status bit positions
`define IRQ_PIN_RESET 0
`define IRQ_SOFT_RESET 1
`define IRQ_WDT_TIMEOUT 2
`define IRQ_CONFIG_MISMATCH 3
`define IRQ_WIDTH 4

// Unprogrammed watchdog configuration
`define WDT_CFG_ALWAYS_ON 2'h3

// AXI responses
`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2

`endif

// ### hw/sync_two_flop.v
// Two flip-flop synchroniser for a vector of levels
`timescale 1ns/1ps
`default_nettype none
module sync_two_flop #(
  parameter WIDTH = 4
) (
  input wire clock,
  input wire reset,
  input wire [WIDTH-1:0] asyncIn,
  output reg [WIDTH-1:0] syncOut
);
  reg [WIDTH-1:0] stageOne;

  // First stage feeds only the second
  always @(posedge clock or posedge reset)
  begin
    if (reset)
    begin
      stageOne <= {WIDTH{1'b0}};
      syncOut <= {WIDTH{1'b0}};
    end
    else
    begin
      stageOne <= asyncIn;
      syncOut <= stageOne;
    end
  end
endmodule // sync_two_flop
`default_nettype wire

// ### tb/reset_cause_monitor.sv
// Bus and field checks for the reset-cause block
`timescale 1ns/1ps
`default_nettype none
`include "reset_cause_defines.vh"
module reset_cause_monitor (
  input wire clock,
  input wire reset,
  input wire [1:0] watchdogConfigEnable,
  input wire [3:0] s_axi_araddr,
  input wire s_axi_arvalid,
  input wire s_axi_arready,
  input wire [31:0] s_axi_rdata,
  input wire [1:0] s_axi_rresp,
  input wire s_axi_rvalid,
  input wire s_axi_rready,
  input wire s_axi_awready,
  input wire s_axi_wready,
  input wire [1:0] s_axi_bresp,
  input wire s_axi_bvalid,
  input wire s_axi_bready,
  input wire watchdogEnable
);
  // One domain, so clock and reset are given once
  default clocking cb @(posedge clock); endclocking
  default disable iff (reset);
  a_bresp_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response dropped early");
  a_rdata_hold: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data dropped early");
  a_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read answer late");
  a_ar_blocked: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("second read taken");
  a_wr_blocked: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
    else $error("second write taken");
  a_bad_read: assert property (s_axi_arvalid && s_axi_arready && s_axi_araddr == 4'hC
    |=> s_axi_rresp == `RESP_SLVERR && s_axi_rdata == 32'h0) else $error("unmapped read wrong");
  a_unused_zero: assert property (
    s_axi_rvalid |-> s_axi_rdata[31:12] == 20'h0 && !s_axi_rdata[10]) else $error("unused bits set");
  a_wdog_forced: assert property (
    watchdogConfigEnable == `WDT_CFG_ALWAYS_ON |=> watchdogEnable) else $error("watchdog not forced");
endmodule // reset_cause_monitor
bind reset_cause_flags reset_cause_monitor i_mon (.*);
`default_nettype wire

// ### tb/reset_cause_flags_bench.sv
// Self-checking bench for the reset-cause block
`timescale 1ns/1ps
`default_nettype none
`include "reset_cause_defines.vh"
module reset_cause_flags_bench;
  logic clock = 0;
  logic reset = 1;
  logic [3:0] ev = 0;
  logic [1:0] cfg = 0;
  logic [3:0] awaddr = 0, araddr = 0;
  logic awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
  logic [31:0] wdata = 0;
  wire awready, wready, bvalid, arready, rvalid, wdog, coreAct, flashAct, irq;
  wire [1:0] bresp, rresp;
  wire [31:0] rdata;
  logic [31:0] expQ[$];
  logic [15:0] flagBit[4] = '{16'h0080, 16'h0040, 16'h0010, 16'h0200};
  logic [15:0] v;
  int err_count = 0;
  int checks_done = 0;
  always #12.5 clock = ~clock;
  // Idle and sleep inputs and strobes are tied
  reset_cause_flags i_dut (.clock(clock), .reset(reset), .pinResetEvent(ev[0]),
    .softResetEvent(ev[1]), .watchdogTimeoutEvent(ev[2]), .configMismatchEvent(ev[3]),
    .sleepEntered(1'b0), .idleEntered(1'b0), .watchdogConfigEnable(cfg),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .watchdogEnable(wdog), .coreRegulatorSleepActive(coreAct),
    .flashRegulatorSleepActive(flashAct), .interrupt(irq));
  task check(input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp)
    begin
      err_count++;
      $display("MISMATCH at %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task print_verdict;
    $display("mismatches %0d comparisons %0d", err_count, checks_done);
    if (err_count == 0 && checks_done > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  // A bound used up counts as a mismatch
  task bound(input int n);
    if (n >= 50)
    begin
      err_count++;
      print_verdict;
    end
  endtask
  task axiWrite(input logic [3:0] a, input logic [15:0] d, input logic [1:0] r);
    int n;
    expQ.push_back({30'h0, r});
    @(posedge clock);
    awaddr <= a;
    wdata <= {16'h0, d};
    awvalid <= 1;
    wvalid <= 1;
    // Response ready raised with the request, held until bvalid is seen
    bready <= 1;
    for (n = 0; n < 50; n++)
    begin
      @(posedge clock);
      if (awready) awvalid <= 0;
      if (wready) wvalid <= 0;
      if (bvalid) break;
    end
    bready <= 0;
    bound(n);
  endtask
  task axiRead(input logic [3:0] a, input logic [15:0] exp);
    int n;
    expQ.push_back({16'h0, exp});
    @(posedge clock);
    araddr <= a;
    arvalid <= 1;
    rready <= 1;
    for (n = 0; n < 50; n++)
    begin
      @(posedge clock);
      if (arready) arvalid <= 0;
      if (rvalid) break;
    end
    rready <= 0;
    bound(n);
  endtask
  // Each answer is held against the oldest note
  always @(posedge clock)
    if ((rvalid && rready) || (bvalid && bready))
      check(rvalid ? rdata : {30'h0, bresp}, expQ.pop_front());
  initial
  begin
    int i;
    void'($urandom(32'hB91C));
    repeat (16) @(posedge clock);
    reset <= 0;
    axiRead(4'h0, 16'h0003);
    axiRead(4'hC, 16'h0000);
    axiWrite(4'h8, 16'h000E, `RESP_OKAY);
    for (i = 0; i < 4; i++)
    begin
      @(posedge clock);
      ev <= 4'h1 << i;
      repeat (8) @(posedge clock);
      ev <= 0;
      check(irq, i != 0);
      axiRead(4'h0, flagBit[i] | 16'h0003);
      axiWrite(4'h4, 16'h1 << i, `RESP_OKAY);
      axiWrite(4'h0, 16'h0003, `RESP_OKAY);
      axiRead(4'h4, 16'h0000);
      check(irq, 0);
    end
    for (i = 0; i < 4; i++)
    begin
      v = 16'($urandom) & 16'h0BFF;
      axiWrite(4'h0, v | 16'hF400, `RESP_OKAY);
      axiRead(4'h0, v);
      check({flashAct, coreAct, wdog}, {v[11], v[8], v[5]});
      axiRead(4'h4, 16'h0000);
    end
    cfg <= 2'h3;
    axiWrite(4'h0, 16'h0000, `RESP_OKAY);
    check(wdog, 1);
    axiWrite(4'hC, 16'hFFFF, `RESP_SLVERR);
    axiRead(4'h0, 16'h0000);
    reset <= 1;
    @(posedge clock);
    reset <= 0;
    axiRead(4'h0, 16'h0003);
    print_verdict;
  end
endmodule // reset_cause_flags_bench
`default_nettype wire
